// ===== logic/dbcrb_register_bank.sv
/*
  Register bank of a two-output step-down converter: status, latched
  select codes, enables, ramp settings and read-to-clear fault flags.
  Assumes the serial engine issues one byte access per strobe, walks the
  pointer itself across bursts, and all analog inputs are synchronous.
*/
// How it works
// - System status shows six live condition bits; bits 7:6 read zero.
// - Two registers show five-bit latched select codes, upper bits zero.
// - Output enable is software bit ORed with the enable pin.
// - Enable bits 0 and 1, low-power bits 4 and 5, reset zero.
// - Soft-start rate in bits 2:0, reset code four.
// - Soft-stop rate in bits 5:3, same code order, reset zero.
// - Fault flags are sticky; a read returns then clears them.
// - Short-circuit events set bit 5 (out two) and bit 4 (out one).
// - Power-good faults set bit 1 (out two) and bit 0 (out one).
// - Mask bits match flag positions; masks and reserved reset to one.
// - Short status reads one only while enabled and below threshold.
// - Power-good status reads one only while enabled and above threshold.
// - Voltage code maps base plus code times step, saturating.
// - Rise rate in bits 2:0, soft-start encoding, reset four.
// - Fall rate in bits 5:3, soft-stop encoding, reset zero.
// - Byte registers, byte addresses; engine increments the pointer.
// - Source register bit 1 fault pending, bit 0 system pending.
// - Each system condition rising sets a read-to-clear flag.
`timescale 1ns/1ps
module dbcrb_register_bank #(
  parameter int SEL_W = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port from the serial engine
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Live system conditions
  input wire logic extClockSeen,
  input wire logic biasOnAlternateInput,
  input wire logic inputUndervoltage,
  input wire logic thermalShutdown,
  input wire logic thermalWarningHigh,
  input wire logic thermalWarningLow,
  // Select pin codes and capture strobe
  input wire logic [SEL_W-1:0] selectPinOneCode,
  input wire logic [SEL_W-1:0] selectPinTwoCode,
  input wire logic selectCapture,
  // Enable pins and analog monitors
  input wire logic out1EnablePin,
  input wire logic out2EnablePin,
  input wire logic out1BelowShort,
  input wire logic out2BelowShort,
  input wire logic out1AbovePowerGood,
  input wire logic out2AbovePowerGood,
  input wire logic out1ShortFault,
  input wire logic out2ShortFault,
  input wire logic out1PowerGoodFault,
  input wire logic out2PowerGoodFault,
  // Controls to the converter
  output logic out1Enable,
  output logic out2Enable,
  output logic out1LowPower,
  output logic out2LowPower,
  output logic forbidAlternateBias,
  output logic alwaysWatchTemperature,
  output logic [1:0] powerGoodTimeout,
  output logic [2:0] softStartRate,
  output logic [2:0] softStopRate,
  output logic [7:0] out1VoltageCode,
  output logic [1:0] out1VoltageRange,
  output logic [2:0] out1RiseRate,
  output logic [2:0] out1FallRate,
  output logic faultPending,
  output logic systemEventPending
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] biasCfg_r;
  logic [7:0] protCfg_r;
  logic [7:0] enCtrl_r;
  logic [7:0] glbRamp_r;
  logic [7:0] fltMasks_r;
  logic [7:0] vcode_r;
  logic [7:0] outCfg_r;
  logic [7:0] fltFlags_r;
  logic [7:0] fltFlags_nxt;
  logic [7:0] sysFlags_r;
  logic [7:0] sysFlags_nxt;
  logic [7:0] sysPrev_r;
  logic [SEL_W-1:0] selOne_r;
  logic [SEL_W-1:0] selTwo_r;
  logic [7:0] rdata_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic wrBias = regWrite && hit(regAddr, dbcrb_pkg::BIAS_CFG_ADDR);
  wire logic wrProt = regWrite && hit(regAddr, dbcrb_pkg::PROTECTION_CONFIG_ADDR);
  wire logic wrEn = regWrite && hit(regAddr, dbcrb_pkg::EN_CTRL_ADDR);
  wire logic wrGlb = regWrite && hit(regAddr, dbcrb_pkg::GLB_RAMP_ADDR);
  wire logic wrMask = regWrite && hit(regAddr, dbcrb_pkg::FLT_MASKS_ADDR);
  wire logic wrVcode = regWrite && hit(regAddr, dbcrb_pkg::OUT1_VCODE_ADDR);
  wire logic wrCfg = regWrite && hit(regAddr, dbcrb_pkg::OUT1_CFG_ADDR);
  wire logic rdFlt = regRead && hit(regAddr, dbcrb_pkg::FLT_FLAGS_ADDR);
  wire logic rdSys = regRead && hit(regAddr, dbcrb_pkg::SYS_FLAGS_ADDR);

  // ----------------------------------------------------------------
  // Live status
  // ----------------------------------------------------------------
  wire logic [7:0] sysLive = {2'b00, extClockSeen, biasOnAlternateInput,
    inputUndervoltage, thermalShutdown, thermalWarningHigh,
    thermalWarningLow};
  wire logic [7:0] sysRise = sysLive & ~sysPrev_r & dbcrb_pkg::SYS_BITS;
  assign out1Enable = enCtrl_r[dbcrb_pkg::EN_OUT1_BIT] | out1EnablePin;
  assign out2Enable = enCtrl_r[dbcrb_pkg::EN_OUT2_BIT] | out2EnablePin;
  wire logic [7:0] fltStatus = {2'b00,
    out2Enable & out2BelowShort, out1Enable & out1BelowShort,
    2'b00,
    out2Enable & out2AbovePowerGood, out1Enable & out1AbovePowerGood};
  wire logic [7:0] fltEvents = {2'b00, out2ShortFault, out1ShortFault,
    2'b00, out2PowerGoodFault, out1PowerGoodFault};
  // Set term ORed after the clear so a coincident event is kept
  assign fltFlags_nxt = (rdFlt ? 8'h00 : fltFlags_r) | fltEvents;
  assign sysFlags_nxt = (rdSys ? 8'h00 : sysFlags_r) | sysRise;
  assign faultPending = |(fltFlags_r & ~fltMasks_r);
  assign systemEventPending = |sysFlags_r;

  // Range is accepted only while output one is off; the host is
  // expected to honour this too, reserved code three is refused.
  wire logic [1:0] newRange = regWdata[7:6];
  wire logic rangeOk = !out1Enable && (newRange != dbcrb_pkg::RANGE_RESERVED);
  wire logic [7:0] cfgWrite = {rangeOk ? newRange : outCfg_r[7:6],
    regWdata[5:0]};

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      biasCfg_r <= 8'h00;
      protCfg_r <= 8'h00;
      enCtrl_r <= 8'h00;
      glbRamp_r <= dbcrb_pkg::GLB_RAMP_RST;
      fltMasks_r <= dbcrb_pkg::FLT_MASKS_RST;
      vcode_r <= dbcrb_pkg::OUT1_VCODE_RST;
      outCfg_r <= dbcrb_pkg::OUT1_CFG_RST;
    end else begin
      if (wrBias) biasCfg_r <= regWdata & dbcrb_pkg::BIAS_CFG_WMASK;
      if (wrProt) protCfg_r <= regWdata & dbcrb_pkg::PROTECTION_CONFIG_WMASK;
      if (wrEn) enCtrl_r <= regWdata & dbcrb_pkg::EN_CTRL_WMASK;
      if (wrGlb) glbRamp_r <= regWdata & dbcrb_pkg::GLB_RAMP_WMASK;
      if (wrMask) fltMasks_r <= regWdata | ~dbcrb_pkg::FLT_BITS;
      if (wrVcode) vcode_r <= regWdata;
      if (wrCfg) outCfg_r <= cfgWrite;
    end
  end

  // ----------------------------------------------------------------
  // Flags and latched codes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fltFlags_r <= 8'h00;
      sysFlags_r <= 8'h00;
      sysPrev_r <= 8'h00;
    end else begin
      fltFlags_r <= fltFlags_nxt;
      sysFlags_r <= sysFlags_nxt;
      sysPrev_r <= sysLive;
    end
  end

  // Codes are caught on a strobe, never under reset itself
  always_ff @(posedge clk) begin
    if (!resetn) begin
      selOne_r <= '0;
      selTwo_r <= '0;
    end else if (selectCapture) begin
      selOne_r <= selectPinOneCode;
      selTwo_r <= selectPinTwoCode;
    end
  end

  // ----------------------------------------------------------------
  // Read mux; unmapped addresses read zero
  // ----------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    unique case (regAddr)
      dbcrb_pkg::INT_SOURCE_ADDR: rdMux = {6'h00, faultPending,
        systemEventPending};
      dbcrb_pkg::SYS_FLAGS_ADDR: rdMux = sysFlags_r;
      dbcrb_pkg::SYS_STATUS_ADDR: rdMux = sysLive;
      dbcrb_pkg::SEL_ONE_ADDR: rdMux = 8'(selOne_r);
      dbcrb_pkg::SEL_TWO_ADDR: rdMux = 8'(selTwo_r);
      dbcrb_pkg::BIAS_CFG_ADDR: rdMux = biasCfg_r;
      dbcrb_pkg::PROTECTION_CONFIG_ADDR: rdMux = protCfg_r;
      dbcrb_pkg::EN_CTRL_ADDR: rdMux = enCtrl_r;
      dbcrb_pkg::GLB_RAMP_ADDR: rdMux = glbRamp_r;
      dbcrb_pkg::FLT_FLAGS_ADDR: rdMux = fltFlags_r;
      dbcrb_pkg::FLT_MASKS_ADDR: rdMux = fltMasks_r;
      dbcrb_pkg::FLT_STATUS_ADDR: rdMux = fltStatus;
      dbcrb_pkg::OUT1_VCODE_ADDR: rdMux = vcode_r;
      dbcrb_pkg::OUT1_CFG_ADDR: rdMux = outCfg_r;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) rdata_r <= 8'h00;
    else if (regRead) rdata_r <= rdMux;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata = rdata_r;
  assign out1LowPower = enCtrl_r[dbcrb_pkg::LP_OUT1_BIT];
  assign out2LowPower = enCtrl_r[dbcrb_pkg::LP_OUT2_BIT];
  assign forbidAlternateBias = biasCfg_r[0];
  assign alwaysWatchTemperature = protCfg_r[2];
  assign powerGoodTimeout = protCfg_r[1:0];
  assign softStartRate = glbRamp_r[2:0];
  assign softStopRate = glbRamp_r[5:3];
  assign out1VoltageCode = vcode_r;
  assign out1VoltageRange = outCfg_r[7:6];
  assign out1RiseRate = outCfg_r[2:0];
  assign out1FallRate = outCfg_r[5:3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  flag_clear_read_a: assert property (@(posedge clk) disable iff (!resetn)
    rdFlt && fltEvents == 8'h00 |=> fltFlags_r == 8'h00)
    else $error("fault flags not cleared by read");
  flag_survive_a: assert property (@(posedge clk) disable iff (!resetn)
    rdFlt && fltEvents[4] |=> fltFlags_r[4])
    else $error("fault event lost on clearing read");
  short_set_a: assert property (@(posedge clk) disable iff (!resetn)
    out2ShortFault |=> fltFlags_r[5])
    else $error("short flag two not set");
  pg_set_a: assert property (@(posedge clk) disable iff (!resetn)
    out1PowerGoodFault |=> fltFlags_r[0])
    else $error("power good flag one not set");
  mask_fixed_a: assert property (@(posedge clk) disable iff (!resetn)
    (fltMasks_r & 8'hcc) == 8'hcc)
    else $error("reserved mask bits not one");
  enable_or_a: assert property (@(posedge clk) disable iff (!resetn)
    out1EnablePin |-> out1Enable)
    else $error("enable pin ignored");
  short_stat_a: assert property (@(posedge clk) disable iff (!resetn)
    !out2Enable |-> !fltStatus[5] && !fltStatus[1])
    else $error("status set while disabled");
  range_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    out1Enable && wrCfg |=> $stable(outCfg_r[7:6]))
    else $error("range changed while enabled");
  sys_set_a: assert property (@(posedge clk) disable iff (!resetn)
    thermalShutdown && !sysPrev_r[2] |=> sysFlags_r[2])
    else $error("shutdown flag not set");
  rd_ro_a: assert property (@(posedge clk) disable iff (!resetn)
    regRead |=> regRdata == $past(rdMux))
    else $error("read data mismatch");
endmodule : dbcrb_register_bank

// ===== inc/dbcrb_pkg.sv
/*
  Register map constants for the dual buck control register bank.
  Assumes an external serial engine that presents byte-wide register
  accesses on a simple address/strobe port.
*/
package dbcrb_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] INT_SOURCE_ADDR = 8'h00;
  localparam logic [7:0] SYS_FLAGS_ADDR = 8'h02;
  localparam logic [7:0] SYS_STATUS_ADDR = 8'h04;
  localparam logic [7:0] SEL_ONE_ADDR = 8'h06;
  localparam logic [7:0] SEL_TWO_ADDR = 8'h07;
  localparam logic [7:0] BIAS_CFG_ADDR = 8'h08;
  localparam logic [7:0] PROTECTION_CONFIG_ADDR = 8'h09;
  localparam logic [7:0] EN_CTRL_ADDR = 8'h0b;
  localparam logic [7:0] GLB_RAMP_ADDR = 8'h11;
  localparam logic [7:0] FLT_FLAGS_ADDR = 8'h20;
  localparam logic [7:0] FLT_MASKS_ADDR = 8'h21;
  localparam logic [7:0] FLT_STATUS_ADDR = 8'h22;
  localparam logic [7:0] OUT1_VCODE_ADDR = 8'h23;
  localparam logic [7:0] OUT1_CFG_ADDR = 8'h25;
  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] GLB_RAMP_RST = 8'h04;
  localparam logic [7:0] FLT_MASKS_RST = 8'hff;
  localparam logic [7:0] OUT1_VCODE_RST = 8'h41;
  localparam logic [7:0] OUT1_CFG_RST = 8'h84;
  localparam logic [7:0] BIAS_CFG_WMASK = 8'h01;
  localparam logic [7:0] PROTECTION_CONFIG_WMASK = 8'h07;
  localparam logic [7:0] EN_CTRL_WMASK = 8'h33;
  localparam logic [7:0] GLB_RAMP_WMASK = 8'h3f;
  localparam logic [7:0] FLT_BITS = 8'h33;
  localparam logic [7:0] SYS_BITS = 8'h3f;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EN_OUT1_BIT = 0;
  localparam int EN_OUT2_BIT = 1;
  localparam int LP_OUT1_BIT = 4;
  localparam int LP_OUT2_BIT = 5;
  localparam int PG_OUT1_BIT = 0;
  localparam int PG_OUT2_BIT = 1;
  localparam int SC_OUT1_BIT = 4;
  localparam int SC_OUT2_BIT = 5;
  localparam int SEL_CODE_W = 5;
  localparam logic [1:0] RANGE_RESERVED = 2'h3;
endpackage : dbcrb_pkg

// ===== verification/dbcrb_host_model.sv
/*
  Host-side model of the serial engine: single byte writes and reads.
  Assumes the bank takes a strobe at the rising edge that sees it high.
*/
`timescale 1ns/1ps
module dbcrb_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdata
);
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // Released lines show the inverse, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask : rd
endmodule : dbcrb_host_model

// ===== verification/dbcrb_tb_top.sv
/*
  Self-checking bench for the register bank: the host model drives the
  register port, the bench drives the converter-side conditions.
*/
`timescale 1ns/1ps
module dual_buck_control_register_bank_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr, regWdata, regRdata, d, v;
  logic regWrite, regRead, selectCapture = 1'b0;
  logic [5:0] sys = 6'h00;
  logic [4:0] selOne = 5'h00, selTwo = 5'h00;
  logic en1Pin = 1'b0, en2Pin = 1'b0, below1 = 1'b0, below2 = 1'b0;
  logic above1 = 1'b0, above2 = 1'b0, sc1 = 1'b0, sc2 = 1'b0;
  logic pg1 = 1'b0, pg2 = 1'b0;
  logic out1Enable, out2Enable, faultPending, systemEventPending;
  logic [2:0] softStartRate, softStopRate, out1RiseRate, out1FallRate;
  logic [1:0] out1VoltageRange, powerGoodTimeout;
  logic out1LowPower, out2LowPower;
  logic forbidAlternateBias, alwaysWatchTemperature;
  logic [7:0] out1VoltageCode;
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] rstAddr [15] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0b, 8'h11, 8'h20, 8'h21, 8'h22, 8'h23, 8'h25, 8'h30};
  logic [7:0] rstVal [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h04, 8'h00, 8'hff, 8'h00, 8'h41, 8'h84, 8'h00};
  logic [7:0] wAddr [8] = '{8'h08, 8'h09, 8'h11, 8'h21, 8'h04, 8'h06,
    8'h22, 8'h23};
  logic [7:0] wExp [8] = '{8'h01, 8'h07, 8'h3f, 8'hcc, 8'h00, 8'h00,
    8'h00, 8'h8c};
  logic [7:0] wData [8] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff,
    8'hff, 8'h8c};
  initial begin
    forever #20 clk = ~clk;
  end
  dbcrb_host_model host_u (.clk(clk), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata));
  dbcrb_register_bank dut_u (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .extClockSeen(sys[5]),
    .biasOnAlternateInput(sys[4]), .inputUndervoltage(sys[3]),
    .thermalShutdown(sys[2]), .thermalWarningHigh(sys[1]),
    .thermalWarningLow(sys[0]), .selectPinOneCode(selOne),
    .selectPinTwoCode(selTwo), .selectCapture(selectCapture),
    .out1EnablePin(en1Pin), .out2EnablePin(en2Pin),
    .out1BelowShort(below1), .out2BelowShort(below2),
    .out1AbovePowerGood(above1), .out2AbovePowerGood(above2),
    .out1ShortFault(sc1), .out2ShortFault(sc2),
    .out1PowerGoodFault(pg1), .out2PowerGoodFault(pg2),
    .out1Enable(out1Enable), .out2Enable(out2Enable),
    .out1LowPower(out1LowPower), .out2LowPower(out2LowPower),
    .forbidAlternateBias(forbidAlternateBias),
    .alwaysWatchTemperature(alwaysWatchTemperature),
    .powerGoodTimeout(powerGoodTimeout),
    .softStartRate(softStartRate), .softStopRate(softStopRate),
    .out1VoltageCode(out1VoltageCode),
    .out1VoltageRange(out1VoltageRange),
    .out1RiseRate(out1RiseRate), .out1FallRate(out1FallRate),
    .faultPending(faultPending), .systemEventPending(systemEventPending));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    host_u.rd(a, r);
    chk(r, exp);
  endtask : rdchk
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 15; i++) rdchk(rstAddr[i], rstVal[i]);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      host_u.wr(wAddr[i], wData[i]);
      rdchk(wAddr[i], wExp[i]);
    end
    chk({7'h0, forbidAlternateBias}, 8'h01);
    chk({7'h0, alwaysWatchTemperature}, 8'h01);
    chk({6'h0, powerGoodTimeout}, 8'h03);
    chk(out1VoltageCode, 8'h8c);
    $display("test access_kinds done");
    for (int i = 0; i < 8; i++) begin
      v = {2'b01, i[2:0], ~i[2:0]};
      host_u.wr(8'h11, {2'b00, v[5:0]});
      rdchk(8'h11, {2'b00, v[5:0]});
      chk({5'h0, softStartRate}, {5'h0, v[2:0]});
      chk({5'h0, softStopRate}, {5'h0, v[5:3]});
      host_u.wr(8'h25, v);
      rdchk(8'h25, v);
      chk({5'h0, out1RiseRate}, {5'h0, v[2:0]});
      chk({5'h0, out1FallRate}, {5'h0, v[5:3]});
    end
    host_u.wr(8'h25, 8'hc0);
    rdchk(8'h25, 8'h40);
    host_u.wr(8'h0b, 8'hff);
    rdchk(8'h0b, 8'h33);
    chk({6'h0, out1LowPower, out2LowPower}, 8'h03);
    chk({6'h0, out1Enable, out2Enable}, 8'h03);
    // Host keeps the range while output one runs; only the rates move
    host_u.wr(8'h25, 8'h5a);
    rdchk(8'h25, 8'h5a);
    chk({6'h0, out1VoltageRange}, 8'h01);
    host_u.wr(8'h0b, 8'h00);
    @(posedge clk);
    en1Pin <= 1'b1;
    @(posedge clk);
    #1;
    chk({6'h0, out1Enable, out2Enable}, 8'h02);
    $display("test ramp_and_enable done");
    @(posedge clk);
    below1 <= 1'b1;
    above2 <= 1'b1;
    rdchk(8'h22, 8'h10);
    @(posedge clk);
    en2Pin <= 1'b1;
    rdchk(8'h22, 8'h12);
    // Shutdown is among the raised conditions so its edge flag is seen
    @(posedge clk);
    selOne <= 5'h15;
    selTwo <= 5'h0a;
    sys <= 6'h2e;
    selectCapture <= 1'b1;
    @(posedge clk);
    selectCapture <= 1'b0;
    rdchk(8'h06, 8'h15);
    rdchk(8'h07, 8'h0a);
    chk({7'h0, systemEventPending}, 8'h01);
    rdchk(8'h00, 8'h01);
    rdchk(8'h04, 8'h2e);
    rdchk(8'h02, 8'h2e);
    rdchk(8'h02, 8'h00);
    $display("test status done");
    host_u.wr(8'h21, 8'hff);
    @(posedge clk);
    sc2 <= 1'b1;
    pg1 <= 1'b1;
    @(posedge clk);
    sc2 <= 1'b0;
    pg1 <= 1'b0;
    @(posedge clk);
    #1;
    chk({7'h0, faultPending}, 8'h00);
    host_u.wr(8'h21, 8'hdf);
    chk({7'h0, faultPending}, 8'h01);
    rdchk(8'h00, 8'h02);
    rdchk(8'h20, 8'h21);
    rdchk(8'h20, 8'h00);
    fork
      host_u.rd(8'h20, d);
      begin
        @(posedge clk);
        sc1 <= 1'b1;
        @(posedge clk);
        sc1 <= 1'b0;
      end
    join
    chk(d, 8'h00);
    rdchk(8'h20, 8'h10);
    $display("test fault_flags done");
    test_done();
  end
endmodule : dual_buck_control_register_bank_tb_top
